// File: include/nhc_pkg.sv
// constants, timing figures and carrier types for the nand host controller
// assumes a single 200 MHz system clock
package nhc_pkg;
	// ----------------------------------------------------------------
	// clock and pin timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned T_WP_NS = 35;
	localparam int unsigned T_WH_NS = 20;
	localparam int unsigned T_RP_NS = 50;
	localparam int unsigned T_REH_NS = 15;
	localparam int unsigned T_WB_NS = 100;
	localparam int unsigned T_ADL_NS = 100;
	localparam int unsigned WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WC_CYC = WP_CYC + (T_WH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RC_CYC = RP_CYC + (T_REH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WB_CYC = (T_WB_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned ADL_CYC = (T_ADL_NS * CLK_MHZ + 999) / 1000;
	// ----------------------------------------------------------------
	// array operation limits
	// ----------------------------------------------------------------
	localparam int unsigned PROG_TYP_US = 200;
	localparam int unsigned PROG_MAX_US = 700;
	localparam int unsigned CBSY_TYP_US = 3;
	localparam int unsigned CBSY_MAX_US = 700;
	localparam int unsigned ERASE_TYP_MS = 2;
	localparam int unsigned ERASE_MAX_MS = 3;
	localparam int unsigned READ_MAX_US = 25;
	localparam int unsigned PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
	localparam int unsigned CBSY_MAX_CYC = CBSY_MAX_US * CLK_MHZ;
	localparam int unsigned ERASE_MAX_CYC = ERASE_MAX_MS * 1000 * CLK_MHZ;
	localparam int unsigned READ_MAX_CYC = READ_MAX_US * CLK_MHZ;
	localparam logic [2:0] NOP_MAX = 3'h4;
	localparam int unsigned SPARE_COL_BIT = 11;
	localparam int unsigned PAGE_ROW_BITS = 6;
	localparam int unsigned ADDR_CYCLES = 4;
	localparam logic [1:0] ERASE_FIRST_ADDR = 2'h2;
	// ----------------------------------------------------------------
	// command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_PROG = 8'h80;
	localparam logic [7:0] CONF_PROG = 8'h10;
	localparam logic [7:0] CONF_CACHE = 8'h15;
	localparam logic [7:0] CMD_ERASE = 8'h60;
	localparam logic [7:0] CONF_ERASE = 8'hD0;
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CONF_READ = 8'h30;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_PROG = 2'h0,
		OP_CACHE = 2'h1,
		OP_ERASE = 2'h2,
		OP_READ = 2'h3
	} nhc_op_t;
	typedef struct packed {
		nhc_op_t op;
		logic blk_bad;
		logic [15:0] col;
		logic [15:0] row;
		logic [11:0] len_m1;
	} nhc_req_t;
	typedef struct packed {
		logic timeout;
		logic refused;
	} nhc_done_t;
endpackage

// File: rtl/nhc_fifo.sv
// small synchronous fifo for program data bytes
// assumes one clock, both sides on sys_clk
`timescale 1ns/100ps
module nhc_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0] cnt_ff;
	wire logic push = in_valid && in_ready;
	wire logic pop = out_valid && out_ready;
	wire logic [AW-1:0] last = AW'(DEPTH - 1);
	assign in_ready = cnt_ff != (AW + 1)'(DEPTH);
	assign out_valid = cnt_ff != '0;
	assign out_data = mem_ff[rp_ff];
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_ff[wp_ff] <= in_data;
		end
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wp_ff <= (wp_ff == last) ? '0 : wp_ff + 1'b1;
			end
			if (pop) begin
				rp_ff <= (rp_ff == last) ? '0 : rp_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule

// File: rtl/nhc_host.sv
// host controller driving an 8-bit nand flash over its strobe pins
// assumes the flash pins are wired straight to the ports; io and ready/busy are asynchronous
//
// What this block does
// - command byte written with command latch high, address latch low, select low.
// - address bytes written with address latch high; full address is four cycles.
// - read bytes fetched by toggling output strobe with latches low, write strobe high.
// - no page programmed over four times in a row between erases, main and spare apart; only the last programmed page is counted.
// - at least 100 ns from last address strobe to first data strobe.
// - never erase or program a factory-marked bad block.
// - page program is 80h, address, data, then confirm 10h.
// - block erase is 60h, block address cycles, then confirm D0h.
`timescale 1ns/100ps
module nhc_host #(
	parameter int unsigned FIFO_DEPTH = 8,
	parameter int unsigned PROG_TO_CYC = nhc_pkg::PROG_MAX_CYC,
	parameter int unsigned CBSY_TO_CYC = nhc_pkg::CBSY_MAX_CYC,
	parameter int unsigned ERASE_TO_CYC = nhc_pkg::ERASE_MAX_CYC,
	parameter int unsigned READ_TO_CYC = nhc_pkg::READ_MAX_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic req_valid,
	output logic req_ready,
	input wire nhc_pkg::nhc_req_t req,
	input wire logic write_protect,
	input wire logic wdata_valid,
	output logic wdata_ready,
	input wire logic [7:0] wdata,
	output logic rdata_valid,
	input wire logic rdata_ready,
	output logic [7:0] rdata,
	output logic done,
	output nhc_pkg::nhc_done_t done_stat,
	output logic cmd_latch,
	output logic addr_latch,
	output logic chip_sel_n,
	output logic write_strobe_n,
	output logic output_strobe_n,
	output logic write_prot_n,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic [7:0] io_in,
	input wire logic ready_busy_n
);
	// ----------------------------------------------------------------
	// state and storage
	// ----------------------------------------------------------------
	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_CMD1 = 9'h002,
		S_ADDR = 9'h004,
		S_ADL = 9'h008,
		S_DATA = 9'h010,
		S_CMD2 = 9'h020,
		S_BUSY = 9'h040,
		S_RDAT = 9'h080,
		S_DONE = 9'h100
	} nhc_state_t;
	nhc_state_t st_ff, nxt_st;
	nhc_pkg::nhc_req_t req_ff;
	logic [7:0] cnt_ff;
	logic [19:0] wt_ff;
	logic [11:0] byte_ff;
	logic [1:0] abyte_ff;
	logic [2:0] rb_sync_ff;
	logic [7:0] io_s1_ff, io_s2_ff, io_s3_ff;
	logic [15:0] last_row_ff;
	logic [2:0] nop_ff [2];
	logic timeout_ff, refused_ff;
	logic cmd_latch_ff, addr_latch_ff, chip_sel_n_ff, write_strobe_n_ff;
	logic output_strobe_n_ff, write_prot_n_ff, io_oe_ff, done_ff;
	logic [7:0] io_out_ff, rdata_ff;
	logic rdata_valid_ff;
	logic f_valid;
	logic [7:0] f_data;
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic is_write_op(input nhc_pkg::nhc_op_t op);
		return op != nhc_pkg::OP_READ;
	endfunction
	wire logic st_wr = st_ff inside {S_CMD1, S_ADDR, S_DATA, S_CMD2};
	wire logic data_wait = (st_ff == S_DATA) && (cnt_ff == '0) && !f_valid;
	wire logic rd_wait = (st_ff == S_RDAT) && (cnt_ff == '0) && !rdata_ready;
	wire logic f_pop = (st_ff == S_DATA) && (cnt_ff == '0) && f_valid;
	wire logic wc_end = cnt_ff == 8'(nhc_pkg::WC_CYC - 1);
	wire logic rc_end = cnt_ff == 8'(nhc_pkg::RC_CYC - 1);
	wire logic rd_take = (st_ff == S_RDAT) && (cnt_ff == 8'(nhc_pkg::RP_CYC - 1));
	wire logic rb_ready = rb_sync_ff[1] && rb_sync_ff[2];
	wire logic io_stable = io_s2_ff == io_s3_ff;
	wire logic req_spare = req.col[nhc_pkg::SPARE_COL_BIT];
	wire logic same_page = req.row == last_row_ff;
	wire logic same_blk = req.row[15:nhc_pkg::PAGE_ROW_BITS] == last_row_ff[15:nhc_pkg::PAGE_ROW_BITS];
	wire logic [2:0] nop_now = same_page ? nop_ff[req_spare] : 3'h0;
	wire logic is_prog = req.op inside {nhc_pkg::OP_PROG, nhc_pkg::OP_CACHE};
	wire logic refuse = (is_prog && nop_now >= nhc_pkg::NOP_MAX)
		|| (is_write_op(req.op) && (write_protect || req.blk_bad));
	wire logic accept = (st_ff == S_IDLE) && req_valid && !refuse;
	wire logic reject = (st_ff == S_IDLE) && req_valid && refuse;
	wire logic [31:0] addr_bytes = {req_ff.row, req_ff.col};
	wire logic [7:0] addr_byte = addr_bytes[{abyte_ff, 3'h0} +: 8];
	wire logic [19:0] to_lim = (req_ff.op == nhc_pkg::OP_PROG) ? 20'(PROG_TO_CYC - 1) :
		(req_ff.op == nhc_pkg::OP_CACHE) ? 20'(CBSY_TO_CYC - 1) :
		(req_ff.op == nhc_pkg::OP_ERASE) ? 20'(ERASE_TO_CYC - 1) :
		20'(READ_TO_CYC - 1);
	wire logic busy_to = wt_ff >= to_lim;
	wire logic [7:0] cmd1_byte = (req_ff.op == nhc_pkg::OP_ERASE) ? nhc_pkg::CMD_ERASE :
		(req_ff.op == nhc_pkg::OP_READ) ? nhc_pkg::CMD_READ : nhc_pkg::CMD_PROG;
	wire logic [7:0] cmd2_byte = (req_ff.op == nhc_pkg::OP_ERASE) ? nhc_pkg::CONF_ERASE :
		(req_ff.op == nhc_pkg::OP_READ) ? nhc_pkg::CONF_READ :
		(req_ff.op == nhc_pkg::OP_CACHE) ? nhc_pkg::CONF_CACHE : nhc_pkg::CONF_PROG;
	wire logic [7:0] cur_byte = (st_ff == S_CMD1) ? cmd1_byte :
		(st_ff == S_ADDR) ? addr_byte :
		(st_ff == S_CMD2) ? cmd2_byte :
		f_pop ? f_data : io_out_ff;
	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			S_IDLE: begin
				if (accept) begin
					nxt_st = S_CMD1;
				end else if (reject) begin
					nxt_st = S_DONE;
				end
			end
			S_CMD1: begin
				if (wc_end) begin
					nxt_st = S_ADDR;
				end
			end
			S_ADDR: begin
				if (wc_end && abyte_ff == 2'(nhc_pkg::ADDR_CYCLES - 1)) begin
					nxt_st = is_prog_ff() ? S_ADL : S_CMD2;
				end
			end
			S_ADL: begin
				if (wt_ff == 20'(nhc_pkg::ADL_CYC - 1)) begin
					nxt_st = S_DATA;
				end
			end
			S_DATA: begin
				if (wc_end && byte_ff == req_ff.len_m1) begin
					nxt_st = S_CMD2;
				end
			end
			S_CMD2: begin
				if (wc_end) begin
					nxt_st = S_BUSY;
				end
			end
			S_BUSY: begin
				// wait out the strobe-to-busy window, then follow the pin
				if (wt_ff >= 20'(nhc_pkg::WB_CYC) && rb_ready) begin
					nxt_st = (req_ff.op == nhc_pkg::OP_READ) ? S_RDAT : S_DONE;
				end else if (busy_to) begin
					nxt_st = S_DONE;
				end
			end
			S_RDAT: begin
				if (rc_end && byte_ff == req_ff.len_m1) begin
					nxt_st = S_DONE;
				end
			end
			S_DONE: begin
				nxt_st = S_IDLE;
			end
		endcase
	end
	function automatic logic is_prog_ff();
		return req_ff.op inside {nhc_pkg::OP_PROG, nhc_pkg::OP_CACHE};
	endfunction
	wire logic cnt_run = (st_wr || st_ff == S_RDAT) && !data_wait && !rd_wait;
	wire logic cnt_wrap = (st_ff == S_RDAT) ? rc_end : wc_end;
	wire logic byte_step = (st_ff inside {S_DATA, S_RDAT}) && cnt_wrap;
	wire logic new_state = nxt_st != st_ff;
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= S_IDLE;
			req_ff <= '0;
			cnt_ff <= '0;
			wt_ff <= '0;
			byte_ff <= '0;
			abyte_ff <= '0;
			timeout_ff <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= (!cnt_run || cnt_wrap) ? '0 : cnt_ff + 8'h01;
			wt_ff <= new_state ? '0 : wt_ff + 20'h00001;
			byte_ff <= new_state ? '0 : byte_ff + 12'(byte_step);
			if (accept) begin
				req_ff <= req;
				abyte_ff <= (req.op == nhc_pkg::OP_ERASE) ? nhc_pkg::ERASE_FIRST_ADDR : 2'h0;
				timeout_ff <= 1'b0;
				refused_ff <= 1'b0;
			end else if (reject) begin
				timeout_ff <= 1'b0;
				refused_ff <= 1'b1;
			end else if (st_ff == S_ADDR && wc_end) begin
				abyte_ff <= abyte_ff + 2'h1;
			end else if (st_ff == S_BUSY && nxt_st == S_DONE) begin
				timeout_ff <= !(wt_ff >= 20'(nhc_pkg::WB_CYC) && rb_ready);
			end
		end
	end
	// partial program tracking per page, main and spare apart
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			last_row_ff <= '0;
			nop_ff[0] <= '0;
			nop_ff[1] <= '0;
		end else if (accept && is_prog) begin
			last_row_ff <= req.row;
			nop_ff[req_spare] <= nop_now + 3'h1;
			nop_ff[!req_spare] <= same_page ? nop_ff[!req_spare] : 3'h0;
		end else if (accept && req.op == nhc_pkg::OP_ERASE && same_blk) begin
			nop_ff[0] <= '0;
			nop_ff[1] <= '0;
		end
	end
	// pin and io synchronisers: three stages, a value counts once stages two and three agree
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rb_sync_ff <= '0;
			io_s1_ff <= '0;
			io_s2_ff <= '0;
			io_s3_ff <= '0;
		end else begin
			rb_sync_ff <= {rb_sync_ff[1:0], ready_busy_n};
			io_s1_ff <= io_in;
			io_s2_ff <= io_s1_ff;
			io_s3_ff <= io_s2_ff;
		end
	end
	// ----------------------------------------------------------------
	// pin drive, all registered
	// ----------------------------------------------------------------
	wire logic wr_low = st_wr && !data_wait && cnt_ff < 8'(nhc_pkg::WP_CYC);
	wire logic rd_low = (st_ff == S_RDAT) && !rd_wait && cnt_ff < 8'(nhc_pkg::RP_CYC);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_latch_ff <= 1'b0;
			addr_latch_ff <= 1'b0;
			chip_sel_n_ff <= 1'b1;
			write_strobe_n_ff <= 1'b1;
			output_strobe_n_ff <= 1'b1;
			write_prot_n_ff <= 1'b0;
			io_oe_ff <= 1'b0;
			io_out_ff <= '0;
			rdata_ff <= '0;
			rdata_valid_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			cmd_latch_ff <= st_ff inside {S_CMD1, S_CMD2};
			addr_latch_ff <= st_ff == S_ADDR;
			chip_sel_n_ff <= st_ff inside {S_IDLE, S_DONE};
			write_strobe_n_ff <= !wr_low;
			output_strobe_n_ff <= !rd_low;
			write_prot_n_ff <= !write_protect;
			io_oe_ff <= st_wr || st_ff == S_ADL;
			if (cnt_ff == '0) begin
				io_out_ff <= cur_byte;
			end
			rdata_valid_ff <= rd_take && io_stable;
			if (rd_take) begin
				rdata_ff <= io_s3_ff;
			end
			done_ff <= st_ff == S_DONE;
		end
	end
	nhc_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.in_valid(wdata_valid),
		.in_ready(wdata_ready),
		.in_data(wdata),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);
	assign req_ready = st_ff == S_IDLE;
	assign rdata_valid = rdata_valid_ff;
	assign rdata = rdata_ff;
	assign done = done_ff;
	assign done_stat = '{timeout: timeout_ff, refused: refused_ff};
	assign cmd_latch = cmd_latch_ff;
	assign addr_latch = addr_latch_ff;
	assign chip_sel_n = chip_sel_n_ff;
	assign write_strobe_n = write_strobe_n_ff;
	assign output_strobe_n = output_strobe_n_ff;
	assign write_prot_n = write_prot_n_ff;
	assign io_out = io_out_ff;
	assign io_oe = io_oe_ff;
endmodule

// File: verif/nhc_host_asserts.sv
// concurrent checks on the pins and request port of the nand host controller
// assumes one clock domain, sys_clk, with rstn as asynchronous active-low reset
`timescale 1ns/100ps
module nhc_host_asserts (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire nhc_pkg::nhc_req_t req,
	input wire logic write_protect,
	input wire logic done,
	input wire nhc_pkg::nhc_done_t done_stat,
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic chip_sel_n,
	input wire logic write_strobe_n,
	input wire logic output_strobe_n,
	input wire logic write_prot_n,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	input wire logic ready_busy_n
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	// ----------------------------------------------------------------
	// helper counters
	// ----------------------------------------------------------------
	logic [7:0] ostb_lo_ff;
	logic [7:0] gap_ff;
	logic was_addr_ff;
	logic [2:0] naddr_ff;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ostb_lo_ff <= 8'h00;
			gap_ff <= 8'h00;
			was_addr_ff <= 1'b0;
			naddr_ff <= 3'h0;
		end else begin
			ostb_lo_ff <= output_strobe_n ? 8'h00 : ostb_lo_ff + 8'h01;
			gap_ff <= $rose(write_strobe_n) ? 8'h01 : gap_ff + {7'h00, gap_ff != 8'hFF};
			if ($fell(write_strobe_n)) begin
				was_addr_ff <= addr_latch;
				naddr_ff <= cmd_latch ? 3'h0 : naddr_ff + {2'h0, addr_latch};
			end
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_latch_excl: assert property (!(cmd_latch && addr_latch))
		else $error("both latch pins high");
	a_wr_frame: assert property ($fell(write_strobe_n) |->
		!chip_sel_n && io_oe && (cmd_latch || addr_latch || write_prot_n))
		else $error("write cycle without select, drive or write enable");
	a_we_low: assert property ($fell(write_strobe_n) |-> (!write_strobe_n)[*7] ##1 write_strobe_n)
		else $error("write strobe low phase not 7 cycles");
	a_we_high: assert property ($rose(write_strobe_n) |-> write_strobe_n[*4])
		else $error("write strobe high phase under 4 cycles");
	a_ostb_low: assert property ($rose(output_strobe_n) |-> ostb_lo_ff == 8'h0A)
		else $error("output strobe low phase not 10 cycles");
	a_ostb_quiet: assert property (!output_strobe_n |->
		!io_oe && write_strobe_n && !cmd_latch && !addr_latch && !chip_sel_n)
		else $error("output strobe low in wrong bus mode");
	a_busy_quiet: assert property (!ready_busy_n |-> write_strobe_n && output_strobe_n)
		else $error("strobe toggled while device busy");
	a_adl_gap: assert property ($fell(write_strobe_n) && !cmd_latch && !addr_latch && was_addr_ff
		|-> gap_ff >= 8'h0D)
		else $error("address to data gap too short");
	a_prog_addr: assert property ($fell(write_strobe_n) && cmd_latch && (io_out == nhc_pkg::CONF_PROG
		|| io_out == nhc_pkg::CONF_CACHE || io_out == nhc_pkg::CONF_READ) |-> naddr_ff == 3'h4)
		else $error("confirm without four address cycles");
	a_erase_addr: assert property ($fell(write_strobe_n) && cmd_latch && io_out == nhc_pkg::CONF_ERASE
		|-> naddr_ff == 3'h2)
		else $error("erase confirm without two address cycles");
	a_refuse_done: assert property (req_valid && req_ready && (write_protect || req.blk_bad)
		&& req.op != nhc_pkg::OP_READ |-> ##[1:3] (done && done_stat.refused))
		else $error("protected or bad block request not refused");
	c_prog: cover property ($fell(write_strobe_n) && cmd_latch && io_out == nhc_pkg::CONF_PROG);
	c_erase: cover property ($fell(write_strobe_n) && cmd_latch && io_out == nhc_pkg::CONF_ERASE);
	c_read: cover property ($rose(output_strobe_n));
	c_tmo: cover property (done && done_stat.timeout);
endmodule

bind nhc_host nhc_host_asserts u_asserts (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid),
	.req_ready(req_ready), .req(req), .write_protect(write_protect), .done(done), .done_stat(done_stat),
	.cmd_latch(cmd_latch), .addr_latch(addr_latch), .chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n),
	.output_strobe_n(output_strobe_n), .write_prot_n(write_prot_n), .io_out(io_out), .io_oe(io_oe),
	.ready_busy_n(ready_busy_n));

// File: verif/nhc_flash_model.sv
// behavioural nand flash device answering the host controller pins
// assumes pins come straight from the host; busy time counted on sys_clk
`timescale 1ns/100ps
module nhc_flash_model (
	input wire logic sys_clk,
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic chip_sel_n,
	input wire logic write_strobe_n,
	input wire logic output_strobe_n,
	input wire logic write_prot_n,
	input wire logic [7:0] io_out,
	input wire logic [15:0] busy_cyc,
	output logic [7:0] io_in,
	output logic ready_busy_n
);
	logic [7:0] last_cmd = 8'hFF;
	logic [7:0] abyte [4];
	logic [7:0] dbuf [16];
	int na = 0;
	int nd = 0;
	int nwr = 0;
	int ridx = 0;
	int bcnt = 0;
	int bstart = 0;
	logic drv = 1'b0;
	logic [7:0] rbyte = 8'h00;
	// ----------------------------------------------------------------
	// bus mode decode
	// ----------------------------------------------------------------
	always @(posedge write_strobe_n) begin
		if (!chip_sel_n && bcnt == 0 && bstart == 0) begin
			nwr++;
			if (cmd_latch && !addr_latch) begin
				last_cmd = io_out;
				na = 0;
				if (io_out == 8'h80) nd = 0;
				if (io_out == 8'h00) ridx = 0;
				if ((io_out == 8'h10 || io_out == 8'hD0) && write_prot_n) bstart = busy_cyc;
				if (io_out == 8'h15 && write_prot_n) bstart = busy_cyc / 4;
				if (io_out == 8'h30) bstart = busy_cyc / 4;
			end else if (addr_latch && !cmd_latch && na < 4) begin
				abyte[na] = io_out;
				na++;
			end else if (!addr_latch && !cmd_latch && write_prot_n && nd < 16) begin
				dbuf[nd] = io_out;
				nd++;
			end
		end
	end
	always @(posedge sys_clk) begin
		if (bstart > 0) begin
			bcnt = bstart;
			bstart = 0;
		end else if (bcnt > 0) bcnt--;
	end
	assign ready_busy_n = (bcnt == 0 && bstart == 0);
	// ----------------------------------------------------------------
	// data output; released bus shows the inverse of the last byte
	// ----------------------------------------------------------------
	always @(negedge output_strobe_n) begin
		if (!chip_sel_n && write_strobe_n && bcnt == 0) begin
			rbyte = {ridx[3:0], ~ridx[3:0]};
			ridx++;
			drv = 1'b1;
		end
	end
	always @(posedge output_strobe_n) drv = 1'b0;
	assign io_in = drv ? rbyte : ~rbyte;
endmodule

// File: verif/tb.sv
// self-checking bench for the nand host controller against the flash model
// assumes busy limits shortened to 300 cycles through the design parameters
`timescale 1ns/100ps
module tb;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic req_valid = 1'b0;
	logic req_ready, wdata_ready, rdata_valid, done, io_oe, ready_busy_n;
	nhc_pkg::nhc_req_t req = '0;
	logic write_protect = 1'b0;
	logic wdata_valid = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic rdata_ready = 1'b0;
	logic [7:0] rdata, io_out, io_in;
	nhc_pkg::nhc_done_t done_stat, st;
	logic cmd_latch, addr_latch, chip_sel_n, write_strobe_n, output_strobe_n, write_prot_n;
	logic [15:0] busy_cyc = 16'h0040;
	logic [15:0] c, r;
	logic [7:0] wq [$];
	logic [7:0] eq [$];
	logic [7:0] rq [$];
	int seed = 6;
	int fails = 0;
	int checks_done = 0;
	int nw;
	always #2.5 sys_clk = ~sys_clk;
	nhc_host #(.PROG_TO_CYC(300), .CBSY_TO_CYC(300), .ERASE_TO_CYC(300), .READ_TO_CYC(300)) u_dut (
		.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready), .req(req),
		.write_protect(write_protect), .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .wdata(wdata),
		.rdata_valid(rdata_valid), .rdata_ready(rdata_ready), .rdata(rdata), .done(done), .done_stat(done_stat),
		.cmd_latch(cmd_latch), .addr_latch(addr_latch), .chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n),
		.output_strobe_n(output_strobe_n), .write_prot_n(write_prot_n), .io_out(io_out), .io_oe(io_oe),
		.io_in(io_in), .ready_busy_n(ready_busy_n));
	nhc_flash_model u_mem (.sys_clk(sys_clk), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
		.chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
		.write_prot_n(write_prot_n), .io_out(io_out), .busy_cyc(busy_cyc), .io_in(io_in),
		.ready_busy_n(ready_busy_n));
	// ----------------------------------------------------------------
	// stream drivers and helpers
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (wdata_valid && wdata_ready === 1'b1) void'(wq.pop_front());
		wdata_valid <= wq.size() > 0;
		if (wq.size() > 0) wdata <= wq[0];
		rdata_ready <= 1'($random(seed));
		if (rdata_valid === 1'b1) rq.push_back(rdata);
	end
	function automatic logic [7:0] exp_rd(input logic [7:0] k);
		return {k[3:0], ~k[3:0]};
	endfunction
	task automatic final_report();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk_b(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_s(input string nm, input logic [1:0] e, input logic [1:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick_until(input int k, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!((k == 0 && req_ready === 1'b1) || (k == 1 && done === 1'b1)
			|| (k == 2 && ready_busy_n === 1'b1)) && n < lim);
		if (n >= lim) begin
			fails++;
			$display("[FAIL] wait %0d expected 1 seen 0", k);
			final_report();
		end
	endtask
	task automatic do_req(input nhc_pkg::nhc_op_t op, input logic bad, input logic [11:0] lm1);
		req <= '{op, bad, c, r, lm1};
		req_valid <= 1'b1;
		tick_until(0, 100);
		req_valid <= 1'b0;
		tick_until(1, 3000);
		st = done_stat;
	endtask
	task automatic load(input int nb);
		logic [7:0] b;
		eq.delete();
		for (int i = 0; i < nb; i++) begin
			b = 8'($random(seed));
			wq.push_back(b);
			eq.push_back(b);
		end
	endtask
	task automatic run_prog(input nhc_pkg::nhc_op_t op);
		do_req(op, 1'b0, 12'(eq.size() - 1));
		chk_s("prog status", 2'h0, st);
		chk_b("confirm", op == nhc_pkg::OP_CACHE ? nhc_pkg::CONF_CACHE : nhc_pkg::CONF_PROG, u_mem.last_cmd);
		chk_b("col lo", c[7:0], u_mem.abyte[0]);
		chk_b("col hi", c[15:8], u_mem.abyte[1]);
		chk_b("row lo", r[7:0], u_mem.abyte[2]);
		chk_b("row hi", r[15:8], u_mem.abyte[3]);
		chk_b("data count", 8'(eq.size()), 8'(u_mem.nd));
		foreach (eq[i]) chk_b("data", eq[i], u_mem.dbuf[i]);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		chk_b("select in reset", 8'h01, {7'h00, chip_sel_n});
		rstn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk_b("wp pin", 8'h01, {7'h00, write_prot_n});
		c = 16'h0000;
		r = 16'h0000;
		load(9);
		repeat (15) @(posedge sys_clk);
		chk_b("fifo full", 8'h00, {7'h00, wdata_ready});
		run_prog(nhc_pkg::OP_PROG);
		$display("end test fifo_program");
		for (int i = 0; i < 6; i++) begin
			c = 16'($random(seed)) & 16'h0FFF;
			r = 16'($random(seed));
			busy_cyc <= 16'h0010 + (16'($random(seed)) & 16'h00FF);
			load(1 + ($unsigned($random(seed)) % 16));
			run_prog(i[0] ? nhc_pkg::OP_CACHE : nhc_pkg::OP_PROG);
		end
		$display("end test random_program");
		r = 16'h0040;
		do_req(nhc_pkg::OP_ERASE, 1'b0, 12'h000);
		chk_s("erase status", 2'h0, st);
		chk_b("erase cmd", nhc_pkg::CONF_ERASE, u_mem.last_cmd);
		chk_b("blk lo", r[7:0], u_mem.abyte[0]);
		chk_b("blk hi", r[15:8], u_mem.abyte[1]);
		rq.delete();
		do_req(nhc_pkg::OP_READ, 1'b0, 12'h007);
		chk_s("read status", 2'h0, st);
		chk_b("read count", 8'h08, 8'(rq.size()));
		foreach (rq[i]) chk_b("read data", exp_rd(8'(i)), rq[i]);
		$display("end test erase_read");
		for (int k = 0; k < 4; k++) begin
			write_protect <= ~k[0];
			nw = u_mem.nwr;
			do_req(k[1] ? nhc_pkg::OP_ERASE : nhc_pkg::OP_PROG, k[0], 12'h000);
			chk_s("refused", 2'h1, st);
			chk_b("pin writes", 8'(nw), 8'(u_mem.nwr));
		end
		write_protect <= 1'b0;
		$display("end test refusals");
		r = 16'h0085;
		for (int k = 0; k < 7; k++) begin
			c = (k == 5) ? 16'h0800 : 16'h0000;
			if (k == 6) do_req(nhc_pkg::OP_ERASE, 1'b0, 12'h000);
			if (k != 4) load(1);
			do_req(nhc_pkg::OP_PROG, 1'b0, 12'h000);
			chk_s("partial", (k == 4) ? 2'h1 : 2'h0, st);
		end
		$display("end test partial_program");
		busy_cyc <= 16'h0200;
		load(1);
		do_req(nhc_pkg::OP_PROG, 1'b0, 12'h000);
		chk_s("timeout", 2'h2, st);
		tick_until(2, 1000);
		$display("end test timeout");
		final_report();
	end
endmodule
